// ==== hdl/diag_slot_store.sv ====
// flip-flop storage for the message slots, one write and one read port
module diag_slot_store #(
	parameter int DEPTH = 250,
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port, data one cycle after the address
	input wire logic [7:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH]; // slot contents, no reset needed

	// slot write
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read, out-of-range address reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (int'(rd_addr) < DEPTH) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end
endmodule

// ==== hdl/diagnosis_history_buffer.sv ====
// diagnosis message history ring with mailbox parameter access
`include "diag_history_defs.svh"
module diagnosis_history_buffer
	import diag_history_pkg::*;
#(
	parameter int MSG_W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// new diagnostic messages from the device
	input wire logic msg_valid,
	output logic msg_ready,
	input wire severity_t msg_severity,
	input wire logic [MSG_W-1:0] msg_data,
	// emergency forwarding
	output logic emcy_valid,
	output logic [MSG_W-1:0] emcy_data,
	// master parameter access by entry index
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [7:0] acc_index,
	input wire logic [15:0] acc_wdata,
	output logic acc_done,
	output logic acc_abort,
	output logic [31:0] acc_abort_code,
	output logic [MSG_W-1:0] acc_rdata
);
	// stored state
	logic [15:0] flags; // flag word, bit 5 set by hardware only
	logic [7:0] max_cnt; // maximum-message count
	logic [7:0] count; // messages held
	logic [7:0] oldest; // ring position of the oldest message
	logic [7:0] ack_cnt; // oldest entries that are acknowledged
	logic [7:0] newest_ack; // newest-acknowledged index
	logic [7:0] hi_mark; // positions ever filled since last clear
	logic unread; // newest message not read yet
	logic rd_slot; // answer comes from the slot store
	logic [15:0] reg_q; // registered parameter read value
	logic [MSG_W-1:0] slot_q; // slot store read data

	// access decode
	wire is_wr = acc_req & acc_write;
	wire is_rd = acc_req & ~acc_write;
	wire ack_mode = flags[`FLAG_ACK_MODE];
	wire wr_ackidx = is_wr & (acc_index == `SI_NEWEST_ACK);
	wire wr_ack_zero = wr_ackidx & (acc_wdata == 16'h0000);
	wire wr_ack_low = wr_ackidx & (acc_wdata != 16'h0000)
		& (acc_wdata < 16'h0006);
	wire wr_ack_big = wr_ackidx & (acc_wdata[15:8] != 8'h00);
	wire wr_ack_slot = wr_ackidx & ~wr_ack_low & ~wr_ack_zero & ~wr_ack_big;
	wire wr_max = is_wr & (acc_index == `SI_MAX_COUNT);
	wire max_ok = (acc_wdata != 16'h0000)
		& (acc_wdata <= {8'h00, `MAX_MESSAGES});
	wire wr_flags = is_wr & (acc_index == `SI_FLAGS);

	// slot lookup: written value for writes, else the accessed index
	wire [7:0] chk_index = is_wr ? acc_wdata[7:0] : acc_index;
	wire [7:0] chk_pos = chk_index - `SI_FIRST_SLOT;
	wire [7:0] rel = (chk_pos >= oldest) ? chk_pos - oldest
		: chk_pos + max_cnt - oldest;
	wire held = (chk_index >= `SI_FIRST_SLOT) & (chk_pos < max_cnt)
		& (rel < count);

	// ring positions
	wire full = (count == max_cnt);
	wire [8:0] tail_sum = {1'b0, oldest} + {1'b0, count};
	wire [8:0] tail_wrap = (tail_sum >= {1'b0, max_cnt})
		? tail_sum - {1'b0, max_cnt} : tail_sum;
	wire [7:0] tail_pos = tail_wrap[7:0];
	wire [7:0] newest_pos = (tail_pos == 8'h00) ? max_cnt - 8'h01
		: tail_pos - 8'h01;
	wire [7:0] oldest_inc = (oldest + 8'h01 == max_cnt) ? 8'h00
		: oldest + 8'h01;
	wire [8:0] del_sum = {1'b0, oldest} + {1'b0, ack_cnt};
	wire [8:0] del_wrap = (del_sum >= {1'b0, max_cnt})
		? del_sum - {1'b0, max_cnt} : del_sum;
	wire [7:0] newest_index = (count == 8'h00) ? 8'h00
		: newest_pos + `SI_FIRST_SLOT;

	// message arrival; writes stall messages so the two never collide
	assign msg_ready = ~is_wr;
	wire take = msg_valid & msg_ready;
	wire filtered = (msg_severity == sev_info & flags[`FLAG_NO_INFO])
		| (msg_severity == sev_warn & flags[`FLAG_NO_WARN])
		| (msg_severity == sev_error & flags[`FLAG_NO_ERROR]);
	wire no_room = full & ack_mode & (ack_cnt == 8'h00);
	wire store = take & ~filtered & ~no_room;
	wire discard = take & ~filtered & no_room;
	wire replace = store & full;
	wire overrun = replace & ~ack_mode & (ack_cnt == 8'h00);
	wire [7:0] wr_pos = full ? oldest : tail_pos;

	// clearing actions
	wire clear_all = (wr_max & max_ok) | (wr_ack_zero & ~ack_mode);
	wire del_acked = wr_ack_zero & ack_mode;
	wire ack_set = wr_ack_slot & held;
	wire ack_load = wr_ack_slot & (held | ~ack_mode);

	// next values of the ring state
	wire [7:0] next_count = clear_all ? 8'h00
		: del_acked ? count - ack_cnt
		: (store & ~full) ? count + 8'h01 : count;
	wire [7:0] next_oldest = clear_all ? 8'h00
		: del_acked ? del_wrap[7:0]
		: replace ? oldest_inc : oldest;
	wire [7:0] next_ack_cnt = (clear_all | del_acked) ? 8'h00
		: ack_set ? rel + 8'h01
		: (replace & ack_cnt != 8'h00) ? ack_cnt - 8'h01 : ack_cnt;
	wire [7:0] next_newest_ack = (clear_all | del_acked | overrun) ? 8'h00
		: (replace & ack_cnt == 8'h01) ? 8'h00
		: ack_load ? acc_wdata[7:0] : newest_ack;
	wire next_discard = overrun | discard
		| (flags[`FLAG_DISCARD] & ~clear_all);
	wire [15:0] next_flags = wr_flags
		? {10'h000, next_discard, acc_wdata[4:0]}
		: {10'h000, next_discard, flags[4:0]};
	wire [7:0] next_hi = clear_all ? 8'h00
		: (store & (wr_pos + 8'h01 > hi_mark)) ? wr_pos + 8'h01 : hi_mark;
	wire read_newest = is_rd & (count != 8'h00) & (acc_index == newest_index);
	wire next_unread = store | (unread & ~clear_all & ~read_newest);
	wire new_avail = ack_mode ? (count > ack_cnt) : unread;

	// answer decode
	wire abort_low = wr_ack_low;
	wire abort_rng = (wr_ack_slot & ~held & ack_mode) | wr_ack_big
		| (wr_max & ~max_ok);
	wire [7:0] hi_index = (hi_mark == 8'h00) ? 8'h00
		: hi_mark + 8'h05;
	wire [15:0] reg_val = (acc_index == `SI_HIGHEST) ? {8'h00, hi_index}
		: (acc_index == `SI_MAX_COUNT) ? {8'h00, max_cnt}
		: (acc_index == `SI_NEWEST) ? {8'h00, newest_index}
		: (acc_index == `SI_NEWEST_ACK) ? {8'h00, newest_ack}
		: (acc_index == `SI_NEW_AVAIL) ? {15'h0000, new_avail}
		: flags;

	// message slots
	diag_slot_store #(.DEPTH(250), .WIDTH(MSG_W)) u_store (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(store),
		.wr_addr(wr_pos),
		.wr_data(msg_data),
		.rd_addr(chk_pos),
		.rd_data(slot_q)
	);

	// ring state, cleared to an empty buffer at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= `FLAGS_RESET;
			max_cnt <= `MAX_MESSAGES;
			count <= 8'h00;
			oldest <= 8'h00;
			ack_cnt <= 8'h00;
			newest_ack <= 8'h00;
			hi_mark <= 8'h00;
			unread <= 1'b0;
		end else begin
			flags <= next_flags;
			max_cnt <= (wr_max & max_ok) ? acc_wdata[7:0] : max_cnt;
			count <= next_count;
			oldest <= next_oldest;
			ack_cnt <= next_ack_cnt;
			newest_ack <= next_newest_ack;
			hi_mark <= next_hi;
			unread <= next_unread;
		end
	end

	// access answer, one cycle after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_done <= 1'b0;
			acc_abort <= 1'b0;
			acc_abort_code <= 32'h00000000;
			rd_slot <= 1'b0;
			reg_q <= 16'h0000;
		end else begin
			acc_done <= acc_req;
			acc_abort <= acc_req & (abort_low | abort_rng);
			acc_abort_code <= abort_low ? `ABORT_TOO_LOW
				: abort_rng ? `ABORT_RANGE : 32'h00000000;
			rd_slot <= is_rd & held;
			reg_q <= (is_rd & acc_index < `SI_FIRST_SLOT) ? reg_val : 16'h0000;
		end
	end
	assign acc_rdata = rd_slot ? slot_q : MSG_W'(reg_q);

	// emergency forwarding of each new message
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			emcy_valid <= 1'b0;
			emcy_data <= '0;
		end else begin
			emcy_valid <= take & flags[`FLAG_EMCY];
			emcy_data <= take ? msg_data : emcy_data;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_low_write;
		wr_ack_low;
	endsequence
	sequence s_nothing_moves;
		$stable(count) && $stable(oldest) && $stable(newest_ack);
	endsequence
	AST_EMCY: assert property (take && flags[0] |=>
		emcy_valid && emcy_data == $past(msg_data))
		else $error("emergency not forwarded");
	AST_NO_INFO: assert property (take && msg_severity == sev_info
		&& flags[1] |=> s_nothing_moves)
		else $error("info message stored while disabled");
	AST_NO_WARN: assert property (take && msg_severity == sev_warn
		&& flags[2] |=> s_nothing_moves and $stable(flags[5]))
		else $error("warning message stored while disabled");
	AST_NO_ERROR: assert property (take && msg_severity == sev_error
		&& flags[3] |=> s_nothing_moves)
		else $error("error message stored while disabled");
	AST_OVERWRITE: assert property (store && full && !ack_mode |=>
		$stable(count) && (oldest != $past(oldest) || max_cnt == 8'h01))
		else $error("full buffer did not overwrite oldest");
	AST_OVERRUN: assert property (overrun |=>
		flags[5] && newest_ack == 8'h00)
		else $error("overrun not reported");
	AST_DISCARD: assert property (discard |=>
		flags[5] && $stable(count) && $stable(oldest))
		else $error("discard not reported");
	AST_FLAG5_RO: assert property (wr_flags |=>
		flags[5] == $past(flags[5]))
		else $error("master write changed bit 5");
	AST_CAPACITY: assert property (count <= max_cnt
		&& max_cnt <= 8'hfa)
		else $error("more messages than allowed");
	AST_NEWEST: assert property (store |=>
		newest_index == $past(wr_pos) + 8'h06)
		else $error("newest index not at written slot");
	AST_CLEAR: assert property (wr_ack_zero && !ack_mode |=>
		count == 8'h00 && newest_ack == 8'h00 && !flags[5] && !new_avail)
		else $error("zero write did not clear history");
	AST_LOW: assert property (s_low_write |=>
		acc_abort && acc_abort_code == 32'h06090032 ##0 s_nothing_moves)
		else $error("low ack write not refused");
endmodule

// ==== pkg/diag_history_defs.svh ====
// constants for the diagnosis history buffer
`ifndef DIAG_HISTORY_DEFS_SVH
`define DIAG_HISTORY_DEFS_SVH
`define SI_HIGHEST 8'h00
`define SI_MAX_COUNT 8'h01
`define SI_NEWEST 8'h02
`define SI_NEWEST_ACK 8'h03
`define SI_NEW_AVAIL 8'h04
`define SI_FLAGS 8'h05
`define SI_FIRST_SLOT 8'h06
`define MAX_MESSAGES 8'hfa
`define FLAG_EMCY 0
`define FLAG_NO_INFO 1
`define FLAG_NO_WARN 2
`define FLAG_NO_ERROR 3
`define FLAG_ACK_MODE 4
`define FLAG_DISCARD 5
`define FLAGS_RESET 16'h0000
`define ABORT_TOO_LOW 32'h06090032
`define ABORT_RANGE 32'h06090030
`endif

// ==== pkg/diag_history_pkg.sv ====
// types shared by the diagnosis history buffer
package diag_history_pkg;
	// severity of an arriving diagnostic message
	typedef enum logic [1:0] {sev_info, sev_warn, sev_error} severity_t;
endpackage

// ==== test/mailbox_master.sv ====
// fieldbus master model issuing mailbox parameter accesses
module mailbox_master (
	// clock
	input wire logic clk,
	// request lines
	output logic acc_req,
	output logic acc_write,
	output logic [7:0] acc_index,
	output logic [15:0] acc_wdata,
	// answer lines
	input wire logic acc_done,
	input wire logic acc_abort,
	input wire logic [31:0] acc_abort_code,
	input wire logic [31:0] acc_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// answer captured while acc_done stands
	logic done;
	logic abort;
	logic [31:0] code;
	logic [31:0] rdata;
	// idle request lines at time zero
	initial begin
		acc_req = 1'b0;
		acc_write = 1'b0;
		acc_index = 8'h00;
		acc_wdata = 16'h0000;
	end
	// one access: drive after a falling edge, take answer a cycle later
	task automatic access(input logic wr, input logic [7:0] idx,
		input logic [15:0] val);
		@(negedge clk);
		acc_req = 1'b1;
		acc_write = wr;
		acc_index = idx;
		acc_wdata = val;
		@(negedge clk);
		done = acc_done;
		abort = acc_abort;
		code = acc_abort_code;
		rdata = acc_rdata;
		acc_req = 1'b0;
		// released lines show the inverse so stale values never match
		acc_index = ~idx;
		acc_wdata = ~val;
	endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the diagnosis history buffer
`include "diag_history_defs.svh"
`define CHK(n, e, s) check(n, e, s)
module tb import diag_history_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// design connections
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic msg_valid = 1'b0;
	logic msg_ready;
	severity_t msg_severity = sev_info;
	logic [31:0] msg_data = 32'h00000000;
	logic emcy_valid;
	logic [31:0] emcy_data;
	logic acc_req, acc_write, acc_done, acc_abort;
	logic [7:0] acc_index;
	logic [15:0] acc_wdata;
	logic [31:0] acc_abort_code, acc_rdata;
	// bookkeeping
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	diagnosis_history_buffer dut_u (.clk(clk), .rst_n(rst_n),
		.msg_valid(msg_valid), .msg_ready(msg_ready),
		.msg_severity(msg_severity), .msg_data(msg_data),
		.emcy_valid(emcy_valid), .emcy_data(emcy_data),
		.acc_req(acc_req), .acc_write(acc_write), .acc_index(acc_index),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_abort(acc_abort),
		.acc_abort_code(acc_abort_code), .acc_rdata(acc_rdata));
	mailbox_master master_u (.clk(clk), .acc_req(acc_req),
		.acc_write(acc_write), .acc_index(acc_index),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_abort(acc_abort),
		.acc_abort_code(acc_abort_code), .acc_rdata(acc_rdata));
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// compare one value
	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// read an entry and compare; every access must be answered
	task automatic rd(input logic [7:0] idx, input logic [31:0] e,
		input string n);
		master_u.access(1'b0, idx, 16'h0000);
		`CHK("acc_done", 32'h1, master_u.done);
		`CHK(n, e, master_u.rdata);
	endtask
	// write an entry
	task automatic wr(input logic [7:0] idx, input logic [15:0] v);
		master_u.access(1'b1, idx, v);
	endtask
	// offer one message, then look at the emergency pulse
	task automatic post(input severity_t s, input logic [31:0] d,
		input logic emcy);
		@(negedge clk);
		msg_valid = 1'b1;
		msg_severity = s;
		msg_data = d;
		`CHK("msg_ready", 32'h1, {31'h0, msg_ready});
		@(posedge clk);
		while (msg_ready !== 1'b1) @(posedge clk);
		@(negedge clk);
		msg_valid = 1'b0;
		msg_data = ~d;
		`CHK("emcy_valid", {31'h0, emcy}, {31'h0, emcy_valid});
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done();
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		rd(`SI_FLAGS, 32'h0, "flags");
		rd(`SI_NEWEST, 32'h0, "newest");
		rd(`SI_MAX_COUNT, 32'h000000fa, "max count");
		post(sev_info, 32'h11110001, 1'b0);
		post(sev_warn, 32'h11110002, 1'b0);
		rd(`SI_NEWEST, 32'h7, "newest");
		rd(8'h06, 32'h11110001, "slot 6");
		rd(`SI_HIGHEST, 32'h7, "highest");
		// each disable bit keeps its own severity out
		for (int i = 0; i < 3; i++) begin
			wr(`SI_FLAGS, 16'h0002 << i);
			post(severity_t'(i), 32'h22220000, 1'b0);
			rd(`SI_NEWEST, 32'h7, "filtered");
		end
		wr(`SI_FLAGS, 16'h0001);
		post(sev_error, 32'h33330003, 1'b1);
		`CHK("emcy_data", 32'h33330003, emcy_data);
		rd(`SI_NEWEST, 32'h8, "newest");
		wr(`SI_FLAGS, 16'h0021);
		rd(`SI_FLAGS, 32'h1, "flags read only");
		wr(`SI_NEWEST_ACK, 16'h0003);
		`CHK("abort", 32'h1, master_u.abort);
		`CHK("abort code", `ABORT_TOO_LOW, master_u.code);
		rd(`SI_NEWEST, 32'h8, "newest kept");
		// overwrite mode with two slots
		wr(`SI_MAX_COUNT, 16'h0002);
		wr(`SI_FLAGS, 16'h0000);
		post(sev_info, 32'h44440001, 1'b0);
		post(sev_info, 32'h44440002, 1'b0);
		post(sev_info, 32'h44440003, 1'b0);
		rd(`SI_NEWEST, 32'h6, "wrapped");
		rd(`SI_NEW_AVAIL, 32'h1, "new unread");
		rd(8'h06, 32'h44440003, "slot 6");
		rd(8'h07, 32'h44440002, "slot 7");
		rd(`SI_FLAGS, 32'h20, "overrun");
		rd(`SI_NEWEST_ACK, 32'h0, "ack index");
		wr(`SI_NEWEST_ACK, 16'h0000);
		rd(`SI_NEWEST, 32'h0, "cleared");
		rd(`SI_FLAGS, 32'h0, "cleared flags");
		rd(`SI_NEW_AVAIL, 32'h0, "cleared new");
		// acknowledge mode with two slots
		wr(`SI_FLAGS, 16'h0010);
		wr(`SI_MAX_COUNT, 16'h0002);
		post(sev_info, 32'h55550001, 1'b0);
		post(sev_info, 32'h55550002, 1'b0);
		post(sev_info, 32'h55550003, 1'b0);
		rd(`SI_NEWEST, 32'h7, "dropped");
		rd(`SI_FLAGS, 32'h30, "discard");
		rd(8'h06, 32'h55550001, "kept");
		wr(`SI_NEWEST_ACK, 16'h0007);
		`CHK("ack abort", 32'h0, master_u.abort);
		rd(`SI_NEW_AVAIL, 32'h0, "all acked");
		post(sev_info, 32'h55550004, 1'b0);
		rd(`SI_NEWEST, 32'h6, "replaced");
		rd(8'h06, 32'h55550004, "slot 6");
		rd(`SI_NEW_AVAIL, 32'h1, "unacked");
		// acknowledging an index beyond the two slots is refused in acknowledge mode
		wr(`SI_NEWEST_ACK, 16'h000a);
		`CHK("range abort", 32'h1, master_u.abort);
		`CHK("range code", `ABORT_RANGE, master_u.code);
		// second reset in mid-run empties the buffer again
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd(`SI_FLAGS, 32'h0, "flags after reset");
		rd(`SI_NEWEST, 32'h0, "newest after reset");
		rd(`SI_MAX_COUNT, 32'h000000fa, "max after reset");
		test_done();
	end
endmodule
